// file: common/otlr_pkg.sv
/*
 * otlr_pkg: command codes, field positions, reset values and limits for the
 * overtemperature threshold and response command registers.
 * assumes: a bus protocol engine outside presents decoded command writes and reads.
 */
package otlr_pkg;
    // command codes as the bus engine presents them
    localparam logic [7:0] OTLR_CMD_FAULT_THR = 8'h4f;
    localparam logic [7:0] OTLR_CMD_FAULT_ACT = 8'h50;
    localparam logic [7:0] OTLR_CMD_WARN_THR = 8'h51;
    // reset values
    localparam logic [15:0] OTLR_FAULT_THR_RST = 16'h0091;
    localparam logic [7:0] OTLR_FAULT_ACT_RST = 8'h3f;
    localparam logic [15:0] OTLR_WARN_THR_RST = 16'h0078;
    // writable mantissa is the low byte of each threshold word
    localparam int OTLR_MANT_W = 8;
    // fault threshold range, degrees
    localparam logic [7:0] OTLR_FAULT_MIN = 8'h78;
    localparam logic [7:0] OTLR_FAULT_MAX = 8'ha5;
    // hysteresis, restore offset and floor, degrees
    localparam logic [7:0] OTLR_HYST = 8'h14;
    localparam logic [7:0] OTLR_WARN_OFFSET = 8'h19;
    localparam logic [7:0] OTLR_WARN_FLOOR = 8'h64;
    // fault action register fields
    localparam int OTLR_SHDN_BIT = 7;
    localparam int OTLR_RETRY_HI = 5;
    localparam int OTLR_RETRY_LO = 3;
    localparam int OTLR_BYPASS_BIT = 4;
    // restart delay in soft-start rise times when retry is enabled
    localparam logic [2:0] OTLR_DELAY_RISES = 3'h7;
    // restart sequencer states
    typedef enum logic [1:0] {OTLR_RUN, OTLR_OFF, OTLR_WAIT, OTLR_START} otlr_state_type;
endpackage

// file: rtl/otlr_regs.sv
/*
 * otlr_regs: overtemperature threshold and response command registers, with
 * hysteretic fault and warning flags and the shutdown/restart selection.
 * assumes: synchronous inputs on clk; temperature sample with a strobe; one
 * write strobe per command from the bus engine, reads following the code alone; an external sequencer
 * reports the end of each soft-start rise time.
 */
`timescale 1ns/10ps
// Operation
// - fault when temperature exceeds fault threshold
// - fault threshold above warning, else error
// - zero exponent, default 145, range 120-165
// - fault sets summary, fault bit, alert
// - fault latched until 20 degrees below
// - select bit chooses ignore or shutdown
// - bandgap fault always shuts down, restarts only if retry set
// - retry 000 stays off, 111 retries
// - other retry values rejected with error
// - only bit 5 stored, field rebuilt
// - delay bits read as bit 5
// - delay 111 waits seven rise times
// - store-all commits fault threshold and retry bit
// - warning sets summary, warning bit, alert
// - warning latched until 20 degrees below
// - warning at or above fault rejected
// - bypass bit skips warning ordering check
// - restore warning is fault minus 25, floor 100
module otlr_regs
    import otlr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // command access from the bus engine
    input wire logic [7:0] cmd_code,
    input wire logic cmd_write,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    // nonvolatile store and restore
    input wire logic store_all,
    input wire logic restore_all,
    input wire logic [7:0] nv_fault_mant,
    input wire logic nv_retry_bit,
    output logic [7:0] nv_fault_mant_out,
    output logic nv_retry_bit_out,
    output logic nv_write,
    // sensor and configuration
    input wire logic [7:0] temp_sample,
    input wire logic temp_valid,
    input wire logic bandgap_fault,
    input wire logic limit_check_bypass,
    input wire logic rise_done,
    // status and control outputs
    output logic overtemp_fault_value,
    output logic overtemp_warning_value,
    output logic temperature_summary_bit,
    output logic comm_error_set,
    output logic invalid_data_set,
    output logic bus_alert,
    output logic output_enable,
    output logic soft_start_req
);

    ////////////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] fault_mant_r, fault_mant_nxt;   // fault threshold mantissa
    logic [7:0] warn_mant_r, warn_mant_nxt;     // warning threshold mantissa
    logic shdn_sel_r, shdn_sel_nxt;             // shutdown_select
    logic retry_bit_r, retry_bit_nxt;           // retry_setting, one stored bit
    logic fault_r, fault_nxt;
    logic warn_r, warn_nxt;
    logic sum_r, sum_nxt;                       // temperature summary, fault or warning
    logic cml_r, cml_nxt;                       // one-cycle error pulse
    logic alert_r, alert_nxt;                   // alert level while a flag stands
    logic [15:0] rdata_r, rdata_nxt;
    logic nvw_r, nvw_nxt;
    logic [7:0] nvm_r, nvm_nxt;
    logic nvr_r, nvr_nxt;

    // legal retry field is all ones or all zeros
    function automatic logic retry_ok(input logic [2:0] f);
        retry_ok = (f == 3'h0) || (f == 3'h7);
    endfunction

    // full fault action byte; bit 6 reads zero, delay bits mirror bit 5
    function automatic logic [7:0] action_byte(input logic s, input logic r);
        action_byte = {s, 1'b0, {3{r}}, {3{r}}};
    endfunction

    // restore value of the warning mantissa
    function automatic logic [7:0] warn_default(input logic [7:0] f);
        logic [7:0] d;
        d = f - OTLR_WARN_OFFSET;
        if (f < OTLR_WARN_OFFSET + OTLR_WARN_FLOOR) begin
            warn_default = OTLR_WARN_FLOOR;
        end else begin
            warn_default = d;
        end
    endfunction

    // flag release test; nine bits so a high sample plus hysteresis cannot wrap and release early
    function automatic logic cooled(input logic [7:0] t, input logic [7:0] lim);
        cooled = ({1'b0, t} + {1'b0, OTLR_HYST}) <= {1'b0, lim};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // command writes, restore, store and flag evaluation
    always_comb begin
        logic [7:0] wm;
        logic [2:0] rf;
        wm = cmd_wdata[OTLR_MANT_W-1:0];
        rf = cmd_wdata[OTLR_RETRY_HI:OTLR_RETRY_LO];
        fault_mant_nxt = fault_mant_r;
        warn_mant_nxt = warn_mant_r;
        shdn_sel_nxt = shdn_sel_r;
        retry_bit_nxt = retry_bit_r;
        fault_nxt = fault_r;
        warn_nxt = warn_r;
        cml_nxt = 1'b0;
        nvw_nxt = 1'b0;
        nvm_nxt = nvm_r;
        nvr_nxt = nvr_r;
        if (restore_all) begin
            // only one retry bit is kept; the field is rebuilt from it
            fault_mant_nxt = nv_fault_mant;
            retry_bit_nxt = nv_retry_bit;
            warn_mant_nxt = warn_default(nv_fault_mant);
        end else if (store_all) begin
            nvw_nxt = 1'b1;
            nvm_nxt = fault_mant_r;
            nvr_nxt = retry_bit_r;
        end else if (cmd_write) begin
            if (cmd_code == OTLR_CMD_FAULT_THR) begin
                // out-of-range or not above warning is refused
                if (wm <= warn_mant_r || wm < OTLR_FAULT_MIN || wm > OTLR_FAULT_MAX) begin
                    cml_nxt = 1'b1;
                end else begin
                    fault_mant_nxt = wm;
                end
            end else if (cmd_code == OTLR_CMD_FAULT_ACT) begin
                if (!retry_ok(rf)) begin
                    cml_nxt = 1'b1;
                end else begin
                    shdn_sel_nxt = cmd_wdata[OTLR_SHDN_BIT];
                    retry_bit_nxt = rf[2];
                end
            end else if (cmd_code == OTLR_CMD_WARN_THR) begin
                if (wm >= fault_mant_r && !limit_check_bypass) begin
                    cml_nxt = 1'b1;
                end else begin
                    warn_mant_nxt = wm;
                end
            end
        end
        // hysteretic flags on each new sample; a bypassed warning limit may be at or above the fault limit
        if (temp_valid) begin
            if (temp_sample > fault_mant_r) begin
                fault_nxt = 1'b1;
            end else if (cooled(temp_sample, fault_mant_r)) begin
                fault_nxt = 1'b0;
            end
            if (temp_sample > warn_mant_r) begin
                warn_nxt = 1'b1;
            end else if (cooled(temp_sample, warn_mant_r)) begin
                warn_nxt = 1'b0;
            end
        end
        // the summary bit stands for either flag
        sum_nxt = fault_nxt | warn_nxt;
        alert_nxt = fault_nxt | warn_nxt | cml_nxt;
        // read data of the addressed command
        if (cmd_code == OTLR_CMD_FAULT_THR) begin
            rdata_nxt = {8'h00, fault_mant_r};
        end else if (cmd_code == OTLR_CMD_FAULT_ACT) begin
            rdata_nxt = {8'h00, action_byte(shdn_sel_r, retry_bit_r)};
        end else if (cmd_code == OTLR_CMD_WARN_THR) begin
            rdata_nxt = {8'h00, warn_mant_r};
        end else begin
            rdata_nxt = 16'h0000;
        end
    end

    // register stage for the command and flag group
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fault_mant_r <= OTLR_FAULT_THR_RST[7:0];
            warn_mant_r <= OTLR_WARN_THR_RST[7:0];
            shdn_sel_r <= OTLR_FAULT_ACT_RST[OTLR_SHDN_BIT];
            retry_bit_r <= OTLR_FAULT_ACT_RST[OTLR_RETRY_HI];
            fault_r <= 1'b0;
            warn_r <= 1'b0;
            sum_r <= 1'b0;
            cml_r <= 1'b0;
            alert_r <= 1'b0;
            rdata_r <= 16'h0000;
            nvw_r <= 1'b0;
            nvm_r <= 8'h00;
            nvr_r <= 1'b0;
        end else begin
            fault_mant_r <= fault_mant_nxt;
            warn_mant_r <= warn_mant_nxt;
            shdn_sel_r <= shdn_sel_nxt;
            retry_bit_r <= retry_bit_nxt;
            fault_r <= fault_nxt;
            warn_r <= warn_nxt;
            sum_r <= sum_nxt;
            cml_r <= cml_nxt;
            alert_r <= alert_nxt;
            rdata_r <= rdata_nxt;
            nvw_r <= nvw_nxt;
            nvm_r <= nvm_nxt;
            nvr_r <= nvr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shutdown and restart selection
    otlr_state_type st_r, st_nxt;
    logic [2:0] rises_r, rises_nxt;     // rise times waited so far
    logic oe_r, oe_nxt;
    logic ss_r, ss_nxt;
    logic trip;

    // a bandgap fault shuts down even when the ignore response is set
    assign trip = (fault_r & shdn_sel_r) | bandgap_fault;

    always_comb begin
        st_nxt = st_r;
        rises_nxt = rises_r;
        ss_nxt = 1'b0;
        case (st_r)
            OTLR_RUN: begin
                if (trip) begin
                    st_nxt = OTLR_OFF;
                end
            end
            OTLR_OFF: begin
                // wait for the cause to clear; no retry holds off for good
                if (!trip && retry_bit_r) begin
                    st_nxt = OTLR_WAIT;
                    rises_nxt = 3'h0;
                end
            end
            OTLR_WAIT: begin
                if (trip) begin
                    st_nxt = OTLR_OFF;
                end else if (rises_r == OTLR_DELAY_RISES) begin
                    st_nxt = OTLR_START;
                    ss_nxt = 1'b1;
                end else if (rise_done) begin
                    rises_nxt = rises_r + 3'h1;
                end
            end
            OTLR_START: begin
                st_nxt = trip ? OTLR_OFF : OTLR_RUN;
            end
            default: st_nxt = OTLR_RUN;
        endcase
        oe_nxt = (st_nxt == OTLR_RUN) || (st_nxt == OTLR_START);
    end

    // register stage for the restart group
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r <= OTLR_RUN;
            rises_r <= 3'h0;
            oe_r <= 1'b1;
            ss_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            rises_r <= rises_nxt;
            oe_r <= oe_nxt;
            ss_r <= ss_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flip-flops
    assign cmd_rdata = rdata_r;
    assign nv_write = nvw_r;
    assign nv_fault_mant_out = nvm_r;
    assign nv_retry_bit_out = nvr_r;
    assign overtemp_fault_value = fault_r;
    assign overtemp_warning_value = warn_r;
    assign temperature_summary_bit = sum_r;
    assign comm_error_set = cml_r;
    assign invalid_data_set = cml_r;
    assign bus_alert = alert_r;
    assign output_enable = oe_r;
    assign soft_start_req = ss_r;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_fault_trip: assert property (@(posedge clk) disable iff (!reset_n)
        temp_valid && temp_sample > fault_mant_r |=> overtemp_fault_value)
        else $error("fault flag not set above threshold");
    a_fault_hold: assert property (@(posedge clk) disable iff (!reset_n)
        fault_r && !(temp_valid && cooled(temp_sample, fault_mant_r)) |=> fault_r)
        else $error("fault flag released early");
    a_warn_trip: assert property (@(posedge clk) disable iff (!reset_n)
        temp_valid && temp_sample > warn_mant_r |=> warn_r && bus_alert)
        else $error("warning flag or alert missing");
    a_warn_reject: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_write && !store_all && !restore_all && cmd_code == OTLR_CMD_WARN_THR
        && !limit_check_bypass && cmd_wdata[7:0] >= fault_mant_r
        |=> $stable(warn_mant_r) && comm_error_set && bus_alert)
        else $error("bad warning write accepted");
    a_retry_reject: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_write && !store_all && !restore_all && cmd_code == OTLR_CMD_FAULT_ACT
        && !retry_ok(cmd_wdata[5:3]) |=> invalid_data_set && $stable(retry_bit_r))
        else $error("bad retry write accepted");
    a_fault_order: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_write && !store_all && !restore_all && cmd_code == OTLR_CMD_FAULT_THR
        && cmd_wdata[7:0] <= warn_mant_r |=> comm_error_set && $stable(fault_mant_r))
        else $error("fault threshold not above warning accepted");
    a_bandgap_off: assert property (@(posedge clk) disable iff (!reset_n)
        bandgap_fault && st_r == OTLR_RUN |=> ##1 !output_enable)
        else $error("bandgap fault did not shut down");
    a_ignore_run: assert property (@(posedge clk) disable iff (!reset_n)
        st_r == OTLR_RUN && !shdn_sel_r && !bandgap_fault |=> output_enable)
        else $error("ignore response shut down");
    a_no_retry: assert property (@(posedge clk) disable iff (!reset_n)
        st_r == OTLR_OFF && !retry_bit_r |=> st_r == OTLR_OFF)
        else $error("restart without retry");
    a_restore_warn: assert property (@(posedge clk) disable iff (!reset_n)
        restore_all |=> warn_mant_r >= OTLR_WARN_FLOOR)
        else $error("restored warning below floor");
endmodule

// file: verification/otlr_host_model.sv
/*
 * otlr_host_model: host side of the command port; writes, reads, store and restore.
 * assumes: the register block takes commands on the rising edge of clk and
 * answers one cycle later.
 */
`timescale 1ns/10ps
module otlr_host_model (
    // clock
    input wire logic clk,
    // command drive
    output logic [7:0] cmd_code,
    output logic cmd_write,
    output logic [15:0] cmd_wdata,
    output logic store_all,
    output logic restore_all,
    // answers
    input wire logic [15:0] cmd_rdata,
    input wire logic comm_error_set,
    input wire logic invalid_data_set
);
    // idle at time zero, nothing requested
    initial begin
        cmd_code = 8'h00;
        cmd_write = 1'b0;
        cmd_wdata = 16'h0000;
        store_all = 1'b0;
        restore_all = 1'b0;
    end

    // one write; a normal host keeps fault above warning, the bench breaks it on purpose
    task automatic wr(input logic [7:0] c, input logic [15:0] d, output logic [1:0] err);
        @(posedge clk);
        cmd_code <= c;
        cmd_wdata <= d;
        cmd_write <= 1'b1;
        @(posedge clk);
        cmd_write <= 1'b0;
        // released data shows the inverse, so stale data cannot look valid
        cmd_wdata <= ~d;
        @(negedge clk);
        // both status pulses come back, so each one is compared on its own
        err = {comm_error_set, invalid_data_set};
    endtask

    // one read; data is registered, so it is taken a cycle after the code
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        @(posedge clk);
        cmd_code <= c;
        @(posedge clk);
        @(negedge clk);
        d = cmd_rdata;
    endtask

    // one-cycle store (0) or restore (1) pulse
    task automatic nv_cmd(input logic restore);
        @(posedge clk);
        store_all <= ~restore;
        restore_all <= restore;
        @(posedge clk);
        store_all <= 1'b0;
        restore_all <= 1'b0;
        @(negedge clk);
    endtask
endmodule

// file: verification/otlr_regs_tb.sv
/*
 * otlr_regs_tb: self-checking bench for the overtemperature register block.
 * assumes: the host model drives the command port; sample and sequencer
 * inputs are driven here at the rising edge, the bandgap fault at the falling edge.
 */
`timescale 1ns/10ps
module otlr_regs_tb
    import otlr_pkg::*;
;
    logic clk, reset_n, cmd_write, store_all, restore_all, nv_retry_bit, nv_retry_bit_out;
    logic nv_write, temp_valid, bandgap_fault, limit_check_bypass, rise_done;
    logic fault, warn, summary, comm_err, inv_data, alert, oe, ss_req;
    logic [7:0] cmd_code, nv_fault_mant, nv_fault_mant_out, temp_sample;
    logic [15:0] cmd_wdata, cmd_rdata;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic nvw_seen = 1'b0; // sticky store pulse
    logic ss_seen = 1'b0; // sticky restart pulse

    otlr_regs uut (.clk(clk), .reset_n(reset_n), .cmd_code(cmd_code), .cmd_write(cmd_write),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .store_all(store_all),
        .restore_all(restore_all), .nv_fault_mant(nv_fault_mant), .nv_retry_bit(nv_retry_bit),
        .nv_fault_mant_out(nv_fault_mant_out), .nv_retry_bit_out(nv_retry_bit_out),
        .nv_write(nv_write), .temp_sample(temp_sample), .temp_valid(temp_valid),
        .bandgap_fault(bandgap_fault), .limit_check_bypass(limit_check_bypass),
        .rise_done(rise_done), .overtemp_fault_value(fault), .overtemp_warning_value(warn),
        .temperature_summary_bit(summary), .comm_error_set(comm_err),
        .invalid_data_set(inv_data), .bus_alert(alert), .output_enable(oe),
        .soft_start_req(ss_req));
    otlr_host_model host (.clk(clk), .cmd_code(cmd_code), .cmd_write(cmd_write),
        .cmd_wdata(cmd_wdata), .store_all(store_all), .restore_all(restore_all),
        .cmd_rdata(cmd_rdata), .comm_error_set(comm_err), .invalid_data_set(inv_data));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // pulses are one cycle wide, so catch them at every falling edge
    always @(negedge clk) begin
        if (nv_write === 1'b1) nvw_seen = 1'b1;
        if (ss_req === 1'b1) ss_seen = 1'b1;
    end
    // hang guard: under two hundred cycles are expected
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            give_verdict();
        end
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // write, compare refusal, read back
    task automatic wcheck(input logic [7:0] c, input logic [15:0] wd, input logic e_exp,
        input logic [15:0] r_exp);
        logic [1:0] e;
        logic [15:0] d;
        host.wr(c, wd, e);
        check(e, {2{e_exp}});
        host.rd(c, d);
        check(d, r_exp);
    endtask
    // one temperature sample; flags are looked at a cycle later
    task automatic samp(input logic [7:0] t);
        @(posedge clk);
        temp_sample <= t;
        temp_valid <= 1'b1;
        @(posedge clk);
        temp_valid <= 1'b0;
        temp_sample <= ~t;
        @(negedge clk);
    endtask
    task automatic rise(input int n);
        repeat (n) begin
            @(posedge clk);
            rise_done <= 1'b1;
            @(posedge clk);
            rise_done <= 1'b0;
        end
    endtask
    // enable moves a couple of cycles after its cause, so allow a short bound
    task automatic wait_oe(input logic exp);
        for (int i = 0; i < 6 && oe !== exp; i++) @(negedge clk);
        check(oe, exp);
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] d;
        reset_n = 1'b0;
        nv_fault_mant = 8'ha5;
        nv_retry_bit = 1'b1;
        temp_sample = 8'h00;
        temp_valid = 1'b0;
        bandgap_fault = 1'b0;
        limit_check_bypass = 1'b0;
        rise_done = 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        host.rd(OTLR_CMD_FAULT_THR, d); check(d, 16'h0091);
        host.rd(OTLR_CMD_FAULT_ACT, d); check(d, 16'h003f);
        host.rd(OTLR_CMD_WARN_THR, d); check(d, 16'h0078);
        wcheck(OTLR_CMD_FAULT_THR, 16'h00a6, 1'b1, 16'h0091);
        wcheck(OTLR_CMD_FAULT_THR, 16'h0077, 1'b1, 16'h0091);
        wcheck(OTLR_CMD_FAULT_THR, 16'h0078, 1'b1, 16'h0091);
        wcheck(OTLR_CMD_FAULT_THR, 16'hff96, 1'b0, 16'h0096);
        wcheck(OTLR_CMD_WARN_THR, 16'h0096, 1'b1, 16'h0078);
        limit_check_bypass <= 1'b1;
        wcheck(OTLR_CMD_WARN_THR, 16'h00a0, 1'b0, 16'h00a0);
        limit_check_bypass <= 1'b0;
        wcheck(OTLR_CMD_WARN_THR, 16'h0064, 1'b0, 16'h0064);
        wcheck(OTLR_CMD_FAULT_ACT, 16'h0028, 1'b1, 16'h003f);
        wcheck(OTLR_CMD_FAULT_ACT, 16'h0010, 1'b1, 16'h003f);
        wcheck(OTLR_CMD_FAULT_ACT, 16'h00c7, 1'b0, 16'h0080);
        wcheck(OTLR_CMD_FAULT_ACT, 16'h0038, 1'b0, 16'h003f);
        // fault 150, warning 100, response ignore
        samp(8'd101); check({warn, summary, alert, fault}, 4'b1110);
        samp(8'd150); check(fault, 1'b0);
        samp(8'd151); check({fault, summary, alert, oe}, 4'b1111);
        samp(8'd131); check(fault, 1'b1);
        samp(8'd130); check(fault, 1'b0);
        samp(8'd81); check(warn, 1'b1);
        samp(8'd80); check({warn, summary, alert}, 3'b000);
        // shutdown response with retry, then seven rise times before restart
        wcheck(OTLR_CMD_FAULT_ACT, 16'h00b8, 1'b0, 16'h00bf);
        samp(8'd151); wait_oe(1'b0);
        samp(8'd130);
        repeat (2) @(posedge clk);
        ss_seen = 1'b0;
        rise(6);
        repeat (3) @(negedge clk);
        check({ss_seen, oe}, 2'b00);
        rise(1);
        repeat (4) @(negedge clk);
        check({ss_seen, oe}, 2'b11);
        // store, then restore a low limit with retry off
        host.nv_cmd(1'b0);
        repeat (2) @(negedge clk);
        check({nvw_seen, nv_retry_bit_out, nv_fault_mant_out}, 10'h396);
        nv_fault_mant <= 8'h78;
        nv_retry_bit <= 1'b0;
        host.nv_cmd(1'b1);
        host.rd(OTLR_CMD_FAULT_THR, d); check(d, 16'h0078);
        host.rd(OTLR_CMD_WARN_THR, d); check(d, 16'h0064);
        host.rd(OTLR_CMD_FAULT_ACT, d); check(d[5:0], 6'h00);
        // fixed detector fault shuts down with the shutdown response still set; retry off keeps output down
        bandgap_fault <= 1'b1;
        wait_oe(1'b0);
        bandgap_fault <= 1'b0;
        rise(8);
        @(negedge clk);
        check(oe, 1'b0);
        give_verdict();
    end
endmodule
